// *** raf_regs.vh ***
// register map, field positions and constants of the receive address filter
`ifndef RAF_REGS_VH
`define RAF_REGS_VH

`define RAF_OFS_STATUS       8'h40
`define RAF_OFS_CTRL         8'h48
`define RAF_OFS_DATA         8'h4c

`define RAF_CTRL_RESET       32'h0000_0000
`define RAF_CTRL_WMASK       32'hFFB8_03FF
`define RAF_CTRL_MASTER      31
`define RAF_CTRL_ALL_BCAST   30
`define RAF_CTRL_ALL_MCAST   29
`define RAF_CTRL_ALL_UCAST   28
`define RAF_CTRL_EXACT       27
`define RAF_CTRL_TPL_HI      26
`define RAF_CTRL_TPL_LO      23
`define RAF_CTRL_GRP_HASH    21
`define RAF_CTRL_IND_HASH    20
`define RAF_CTRL_UL_IGNORE   19
`define RAF_CTRL_ADDR_HI     9
`define RAF_CTRL_ADDR_LO     0

`define RAF_DATA_MASK_HI     17
`define RAF_DATA_MASK_LO     16
`define RAF_DATA_VAL_HI      15
`define RAF_DATA_VAL_LO      0

`define RAF_FADDR_EXACT0     9'h000
`define RAF_FADDR_EXACT1     9'h002
`define RAF_FADDR_EXACT2     9'h004
`define RAF_FADDR_CNT01      9'h006
`define RAF_FADDR_CNT23      9'h008
`define RAF_FADDR_MEM_BIT    9

`define RAF_HASH_BASE_IDX    8'h00
`define RAF_TPL_LOW_BASE     8'h40
`define RAF_TPL_HIGH_BASE    8'h80

`define RAF_DA_BYTES         8'h06
`define RAF_BYTE_SAT         8'h80
`define RAF_UL_BIT           1

`define RAF_CRC_INIT         32'hFFFF_FFFF
`define RAF_CRC_POLY         32'hEDB8_8320

`endif

// *** raf_da_crc.v ***
// running frame check sequence over the destination address bytes
`include "raf_regs.vh"
module raf_da_crc (
  input  wire        clk,
  input  wire        rst,
  input  wire        clear,
  input  wire        enable,
  input  wire [7:0]  data,
  output wire [31:0] crc_value
);
  reg [31:0] crc;

  function [31:0] crc_byte;
    input [31:0] c_in;
    input [7:0]  d;
    reg   [31:0] c;
    integer      k;
    begin
      c = c_in ^ {24'h00_0000, d};
      for (k = 0; k < 8; k = k + 1) begin
        if (c[0])
          c = (c >> 1) ^ `RAF_CRC_POLY;
        else
          c = c >> 1;
      end
      crc_byte = c;
    end
  endfunction

  always @(posedge clk or posedge rst) begin
    if (rst)
      crc <= `RAF_CRC_INIT;
    else if (clear)
      crc <= `RAF_CRC_INIT;
    else if (enable)
      crc <= crc_byte(crc, data);
  end

  assign crc_value = ~crc;
endmodule

// *** raf_filter.v ***
// receive address and pattern filter with its indirect register port
//
// Implementation choice: the AHB-Lite interface to the registers.
`include "raf_regs.vh"
module raf_filter (
  input  wire        clk,
  input  wire        rst,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        rx_sof,
  input  wire        rx_valid,
  input  wire [7:0]  rx_data,
  input  wire        rx_eof,
  output reg         frame_done,
  output reg         frame_accept
);
  // register bus
  reg  [31:0] rx_filter_control;
  reg  [47:0] exact_addr;
  reg  [15:0] tpl_count01;
  reg  [15:0] tpl_count23;
  reg  [17:0] filter_mem [0:255];
  reg         wr_pend;
  reg  [7:0]  wr_addr;
  reg         rd_pend;
  reg  [7:0]  rd_addr;
  reg  [31:0] status_word;
  reg  [31:0] rd_value;
  reg  [17:0] port_value;
  wire [9:0]  faddr;
  wire        bus_go;
  wire [17:0] wr_word;
  wire        rd_go;
  wire        wr_go;
  wire        ctrl_wr;
  wire        port_wr;
  wire        mem_wr;

  // frame side
  reg         in_frame;
  reg  [7:0]  byte_cnt;
  reg  [47:0] da;
  reg  [3:0]  tpl_fail;
  reg  [3:0]  next_fail;
  reg  [3:0]  tpl_hit;
  reg         exact_hit;
  reg         hash_hit;
  reg         last_accept;
  reg  [7:0]  widx;
  reg  [17:0] wsel;
  reg  [7:0]  tbyte;
  reg         tmask;
  reg  [7:0]  tcnt;
  reg  [47:0] cmp_mask;
  reg  [7:0]  hword_idx;
  reg  [17:0] hword;
  reg         is_bcast;
  reg         is_mcast;
  reg         is_ucast;
  reg         decide;
  wire [31:0] crc_value;
  wire        da_byte;
  integer     b;
  reg  [7:0]  hit_cnt;
  reg         acc_bcast;
  reg         acc_mcast;
  reg         acc_ucast;
  reg         acc_hash;
  reg         acc_tpl;
  reg         class_ok;
  integer     h;

  assign bus_go  = hsel && hready && htrans[1];
  assign faddr   = rx_filter_control[`RAF_CTRL_ADDR_HI:`RAF_CTRL_ADDR_LO];
  assign wr_word = hwdata[`RAF_DATA_MASK_HI:`RAF_DATA_VAL_LO];
  assign da_byte = in_frame && rx_valid && (byte_cnt < `RAF_DA_BYTES);

  // template word index for buffer b and frame byte i
  function [7:0] tpl_word;
    input [1:0] buf_no;
    input [6:0] i;
    reg   [7:0] base;
    begin
      base = buf_no[1] ? `RAF_TPL_HIGH_BASE : `RAF_TPL_LOW_BASE;
      tpl_word = base + {1'b0, i[6:1], 1'b0} + {7'h00, buf_no[0]};
    end
  endfunction

  // programmed byte count of buffer b
  function [7:0] tpl_cnt;
    input [1:0]  buf_no;
    input [15:0] c01;
    input [15:0] c23;
    begin
      case (buf_no)
        2'd0:    tpl_cnt = c01[7:0];
        2'd1:    tpl_cnt = c01[15:8];
        2'd2:    tpl_cnt = c23[7:0];
        default: tpl_cnt = c23[15:8];
      endcase
    end
  endfunction

  // filter address falls in the shared ram
  function in_ram;
    input [9:0] f;
    begin
      in_ram = f[`RAF_FADDR_MEM_BIT];
    end
  endfunction

  // byte lane of a template word with its mask bit above it
  function [8:0] tpl_lane;
    input        hi;
    input [17:0] w;
    begin
      if (hi)
        tpl_lane = {w[`RAF_DATA_MASK_HI], w[15:8]};
      else
        tpl_lane = {w[`RAF_DATA_MASK_LO], w[7:0]};
    end
  endfunction

  // decoded register strobes
  assign rd_go   = bus_go && !hwrite;
  assign wr_go   = bus_go && hwrite;
  assign ctrl_wr = wr_pend && (wr_addr == `RAF_OFS_CTRL);
  assign port_wr = wr_pend && (wr_addr == `RAF_OFS_DATA) && !in_ram(faddr);
  assign mem_wr  = wr_pend && (wr_addr == `RAF_OFS_DATA) && in_ram(faddr);

  raf_da_crc u_crc (
    .clk       (clk),
    .rst       (rst),
    .clear     (rx_sof),
    .enable    (da_byte),
    .data      (rx_data),
    .crc_value (crc_value)
  );

  // selected filter location as seen through the data port
  always @* begin
    port_value = 18'h0_0000;
    if (in_ram(faddr))
      port_value = filter_mem[faddr[8:1]];
    else begin
      case (faddr[8:0])
        `RAF_FADDR_EXACT0: port_value = {2'b00, exact_addr[15:0]};
        `RAF_FADDR_EXACT1: port_value = {2'b00, exact_addr[31:16]};
        `RAF_FADDR_EXACT2: port_value = {2'b00, exact_addr[47:32]};
        `RAF_FADDR_CNT01:  port_value = {2'b00, tpl_count01};
        `RAF_FADDR_CNT23:  port_value = {2'b00, tpl_count23};
        default:           port_value = 18'h0_0000;
      endcase
    end
  end

  always @* begin
    status_word = {22'h00_0000, hash_hit, exact_hit, tpl_hit, 2'b00, in_frame, last_accept};
    case (rd_addr)
      `RAF_OFS_CTRL:   rd_value = rx_filter_control;
      `RAF_OFS_DATA:   rd_value = {14'h0000, port_value};
      `RAF_OFS_STATUS: rd_value = status_word;
      default:         rd_value = 32'h0000_0000;
    endcase
  end

  // ahb-lite slave: writes take no wait state, reads take one
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      rd_pend   <= 1'b0;
      rd_addr   <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hresp   <= 1'b0;
      wr_pend <= wr_go;
      if (bus_go)
        wr_addr <= haddr[7:0];
      if (rd_go) begin
        rd_pend   <= 1'b1;
        rd_addr   <= haddr[7:0];
        hreadyout <= 1'b0;
      end else if (rd_pend) begin
        rd_pend   <= 1'b0;
        hrdata    <= rd_value;
        hreadyout <= 1'b1;
      end
    end
  end

  // register writes
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_filter_control <= `RAF_CTRL_RESET;
      exact_addr        <= 48'h0000_0000_0000;
      tpl_count01       <= 16'h0000;
      tpl_count23       <= 16'h0000;
    end else begin
      if (ctrl_wr)
        rx_filter_control <= hwdata & `RAF_CTRL_WMASK;
      if (port_wr) begin
        case (faddr[8:0])
          `RAF_FADDR_EXACT0: exact_addr[15:0]  <= hwdata[15:0];
          `RAF_FADDR_EXACT1: exact_addr[31:16] <= hwdata[15:0];
          `RAF_FADDR_EXACT2: exact_addr[47:32] <= hwdata[15:0];
          `RAF_FADDR_CNT01:  tpl_count01       <= hwdata[15:0];
          `RAF_FADDR_CNT23:  tpl_count23       <= hwdata[15:0];
          default:           tpl_count01       <= tpl_count01;
        endcase
      end
    end
  end

  // filter ram: hash table from 200, templates from 280 and 300
  always @(posedge clk) begin
    if (mem_wr)
      filter_mem[faddr[8:1]] <= wr_word;
  end

  // per-byte template comparison
  always @* begin
    next_fail = tpl_fail;
    widx      = 8'h00;
    wsel      = 18'h0_0000;
    tbyte     = 8'h00;
    tmask     = 1'b0;
    tcnt      = 8'h00;
    for (b = 0; b < 4; b = b + 1) begin
      widx  = tpl_word(b[1:0], byte_cnt[6:0]);
      wsel  = filter_mem[widx];
      {tmask, tbyte} = tpl_lane(byte_cnt[0], wsel);
      tcnt  = tpl_cnt(b[1:0], tpl_count01, tpl_count23);
      if (byte_cnt < tcnt && !tmask && tbyte != rx_data)
        next_fail[b] = 1'b1;
    end
  end

  // address class, exact match and hash lookup
  always @* begin
    cmp_mask = 48'hFFFF_FFFF_FFFF;
    if (rx_filter_control[`RAF_CTRL_UL_IGNORE])
      cmp_mask[`RAF_UL_BIT] = 1'b0;
    hword_idx = `RAF_HASH_BASE_IDX + {3'b000, crc_value[8:4]};
    hword     = filter_mem[hword_idx];
    is_bcast  = (da == 48'hFFFF_FFFF_FFFF);
    is_mcast  = da[0] && !is_bcast;
    is_ucast  = !da[0];
    exact_hit = rx_filter_control[`RAF_CTRL_EXACT] &&
                ((da & cmp_mask) == (exact_addr & cmp_mask));
    hash_hit  = hword[crc_value[3:0]];
    for (h = 0; h < 4; h = h + 1) begin
      hit_cnt = tpl_cnt(h[1:0], tpl_count01, tpl_count23);
      tpl_hit[h] = rx_filter_control[`RAF_CTRL_TPL_LO + h] && !tpl_fail[h] &&
                   hit_cnt != 8'h00 && byte_cnt >= hit_cnt;
    end
    acc_bcast = is_bcast && rx_filter_control[`RAF_CTRL_ALL_BCAST];
    acc_mcast = !is_ucast && rx_filter_control[`RAF_CTRL_ALL_MCAST];
    acc_ucast = is_ucast && rx_filter_control[`RAF_CTRL_ALL_UCAST];
    acc_hash  = hash_hit && ((!is_ucast && rx_filter_control[`RAF_CTRL_GRP_HASH]) ||
                             (is_ucast && rx_filter_control[`RAF_CTRL_IND_HASH]));
    acc_tpl   = (tpl_hit != 4'h0);
    class_ok  = acc_bcast || acc_mcast || acc_ucast || acc_hash || acc_tpl || exact_hit;
    decide    = rx_filter_control[`RAF_CTRL_MASTER] && byte_cnt >= `RAF_DA_BYTES &&
                class_ok;
  end

  // destination address capture, octet 0 in the low byte
  always @(posedge clk or posedge rst) begin
    if (rst)
      da <= 48'h0000_0000_0000;
    else if (rx_sof)
      da <= 48'h0000_0000_0000;
    else if (da_byte)
      da[byte_cnt[2:0] * 8 +: 8] <= rx_data;
  end

  // frame tracking and decision
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      in_frame     <= 1'b0;
      byte_cnt     <= 8'h00;
      tpl_fail     <= 4'h0;
      last_accept  <= 1'b0;
      frame_done   <= 1'b0;
      frame_accept <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      if (rx_sof) begin
        in_frame <= 1'b1;
        byte_cnt <= 8'h00;
        tpl_fail <= 4'h0;
      end else if (in_frame && rx_eof) begin
        in_frame     <= 1'b0;
        frame_done   <= 1'b1;
        frame_accept <= decide;
        last_accept  <= decide;
      end else if (in_frame && rx_valid) begin
        if (byte_cnt < `RAF_BYTE_SAT) begin
          tpl_fail <= next_fail;
          byte_cnt <= byte_cnt + 8'h01;
        end
      end
    end
  end
endmodule

// *** raf_filter_props.sv ***
// bus and frame handshake checks for the receive address filter
module raf_filter_props (
  input wire        clk,
  input wire        rst,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire        rx_eof,
  input wire        frame_done,
  input wire        frame_accept
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ctl_wr;
  logic ctl_on;
  logic rd_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // shadow of the master enable and of the last accepted read
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_wr <= 1'b0;
      ctl_on <= 1'b0;
      rd_q   <= 1'b0;
    end else begin
      ctl_wr <= hsel && hready && htrans[1] && hwrite && haddr[7:0] == 8'h48;
      rd_q   <= hsel && hready && htrans[1] && !hwrite;
      if (ctl_wr)
        ctl_on <= hwdata[31];
    end
  end
  sequence s_rd_req;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence s_wr_req;
    hsel && hready && htrans[1] && hwrite;
  endsequence
  sequence s_rd_ans;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_rd_wait;
    s_rd_req |=> s_rd_ans;
  endproperty
  property p_wr_zero;
    s_wr_req |=> hreadyout && !hresp;
  endproperty
  property p_rdy_one;
    !hreadyout |=> hreadyout;
  endproperty
  property p_low_cause;
    $fell(hreadyout) |-> rd_q;
  endproperty
  property p_rd_hold;
    !$stable(hrdata) |-> !$past(hreadyout) && hreadyout;
  endproperty
  property p_done;
    rx_eof |=> frame_done ##1 !frame_done;
  endproperty
  property p_acc_hold;
    !frame_done |-> $stable(frame_accept);
  endproperty
  property p_master_gate;
    frame_done && !ctl_on |-> !frame_accept;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read answer timing wrong");
  a_wr_zero: assert property (p_wr_zero) else $error("write stalled");
  a_rdy_one: assert property (p_rdy_one) else $error("wait state too long");
  a_low_cause: assert property (p_low_cause) else $error("wait without read");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  a_done: assert property (p_done) else $error("frame done pulse wrong");
  a_acc_hold: assert property (p_acc_hold) else $error("decision moved");
  a_master_gate: assert property (p_master_gate) else $error("accept while off");
endmodule

// *** raf_rx_src.sv ***
// frame source standing in for the receive datapath
module raf_rx_src (
  input  wire        clk,
  output logic       rx_sof,
  output logic       rx_valid,
  output logic [7:0] rx_data,
  output logic       rx_eof
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx_sof = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_eof = 1'b0;
  end
  // idle data line toggles so a stale byte is never seen
  task automatic step(input logic s, input logic v, input logic e, input logic [7:0] d);
    @(posedge clk);
    rx_sof <= s;
    rx_valid <= v;
    rx_eof <= e;
    rx_data <= v ? d : ~rx_data;
  endtask
  task automatic send(input logic [47:0] da, input int gap);
    step(1'b1, 1'b0, 1'b0, 8'h00);
    for (int i = 0; i < 8; i++) begin
      step(1'b0, 1'b1, 1'b0, i < 6 ? da[47 - 8 * i -: 8] : 8'h5a);
      repeat (gap) step(1'b0, 1'b0, 1'b0, 8'h00);
    end
    step(1'b0, 1'b0, 1'b0, 8'h00);
    step(1'b0, 1'b0, 1'b1, 8'h00);
    step(1'b0, 1'b0, 1'b0, 8'h00);
  endtask
endmodule

// *** test_rx_address_pattern_filter.sv ***
// self-checking bench for the receive address filter
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; \
  $display("BAD t=%0t got %h exp %h", $time, got, exp); end end
module test_rx_address_pattern_filter;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] ctl; logic [47:0] da; logic acc;} raf_row_t;
  localparam logic [31:0] en = 32'h8000_0000;
  localparam logic [47:0] st = 48'h0800_1707_2855, mc = 48'h0100_5e00_0001;
  localparam logic [47:0] uc = 48'h0411_2233_4455, bc = 48'hffff_ffff_ffff;
  localparam logic [47:0] pa = 48'h0200_03ff_0402, pb = 48'h1210_1311_9999;
  logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rv, junk;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic        hreadyout, hresp, rx_sof, rx_valid, rx_eof, frame_done, frame_accept;
  logic [7:0]  rx_data;
  int          error_cnt = 0, checks_done = 0;
  logic [31:0] ini [11][2] = '{'{32'h000, 32'h0008}, '{32'h002, 32'h0717},
    '{32'h004, 32'h5528}, '{32'h006, 32'h0406}, '{32'h008, 32'h0002},
    '{32'h280, 32'h0002}, '{32'h284, 32'h2_0103}, '{32'h288, 32'h0204},
    '{32'h282, 32'h1012}, '{32'h286, 32'h1113}, '{32'h300, 32'h2022}};
  raf_row_t rows [19] = '{
    '{32'h4000_0000, bc, 1'b0}, '{en | 32'h4000_0000, bc, 1'b1},
    '{en | 32'h2000_0000, mc, 1'b1}, '{en | 32'h2000_0000, uc, 1'b0},
    '{en | 32'h1000_0000, uc, 1'b1}, '{en, uc, 1'b0},
    '{en | 32'h0800_0000, st, 1'b1},
    '{en | 32'h0800_0000, 48'h0a00_1707_2855, 1'b0},
    '{en | 32'h0808_0000, 48'h0a00_1707_2855, 1'b1},
    '{en | 32'h0800_0000, 48'h5528_0717_0008, 1'b0},
    '{en | 32'h0080_0000, pa, 1'b1}, '{en | 32'h0080_0000, 48'h0200_03ff_0403, 1'b0},
    '{en | 32'h0100_0000, pb, 1'b1}, '{en | 32'h0080_0000, pb, 1'b0},
    '{en | 32'h0200_0000, 48'h2220_aabb_ccdd, 1'b1},
    '{en | 32'h0020_0000, mc, 1'b1}, '{en | 32'h0010_0000, mc, 1'b0},
    '{en | 32'h0010_0000, uc, 1'b1}, '{en | 32'h0020_0000, uc, 1'b0}};
  always #10 clk = ~clk;
  raf_filter DUT (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rx_sof(rx_sof), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_eof(rx_eof), .frame_done(frame_done), .frame_accept(frame_accept));
  raf_rx_src SRC (.clk(clk), .rx_sof(rx_sof), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_eof(rx_eof));
  task automatic wait_rdy(output logic [31:0] d);
    logic r;
    do begin
      @(negedge clk);
      r = hreadyout;
      d = hrdata;
      @(posedge clk);
    end while (r !== 1'b1);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy(d);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy(d);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, junk);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0, rv);
  endtask
  function automatic logic [8:0] hidx(input logic [47:0] da);
    logic [31:0] c;
    c = 32'hffff_ffff;
    for (int i = 0; i < 48; i++)
      c = (c >> 1) ^ ((c[0] ^ da[40 - 8 * (i / 8) + i % 8]) ? 32'hedb8_8320 : 32'h0);
    return ~c[8:0];
  endfunction
  task automatic hash_at(input logic [8:0] x, input logic set);
    wr(8'h48, 32'h0000_0200 + 32'(x[8:5]) * 4 + 32'(x[4]) * 2);
    rd(8'h4c);
    wr(8'h4c, set ? rv | (32'h1 << x[3:0]) : 32'h0000_0000);
  endtask
  task automatic frame(input logic [47:0] da, input int gap, input logic acc);
    SRC.send(da, gap);
    @(negedge clk);
    `CHK(frame_done, 1'b1)
    `CHK(frame_accept, acc)
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(8'h4c);
    `CHK(rv, 32'h0000_0000)
    foreach (ini[i]) begin
      wr(8'h48, ini[i][0]);
      wr(8'h4c, ini[i][1]);
    end
    for (int i = 0; i < 32; i++) begin
      wr(8'h48, 32'h0000_0200 + 2 * i);
      wr(8'h4c, 32'h0000_0000);
    end
    hash_at(hidx(mc), 1'b1);
    hash_at(hidx(uc), 1'b1);
    foreach (rows[i]) begin
      wr(8'h48, rows[i].ctl);
      frame(rows[i].da, i % 2, rows[i].acc);
    end
    wr(8'h48, 32'h0000_0284);
    rd(8'h4c);
    `CHK(rv, 32'h0002_0103)
    wr(8'h48, 32'h0000_0006);
    rd(8'h4c);
    `CHK(rv, 32'h0000_0406)
    rd(8'h44);
    `CHK(rv, 32'h0000_0000)
    wr(8'h48, en | 32'h0020_0000);
    frame(mc, 0, 1'b1);
    rd(8'h40);
    `CHK(rv[1:0], 2'b01)
    `CHK(rv[9], 1'b1)
    `CHK(hresp, 1'b0)
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHK(frame_accept, 1'b0)
    rd(8'h48);
    `CHK(rv, 32'h0000_0000)
    hash_at(hidx(mc), 1'b0);
    wr(8'h48, en | 32'h0020_0000);
    frame(mc, 0, 1'b0);
    summarize();
  end
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    summarize();
  end
endmodule
bind raf_filter raf_filter_props u_props (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .rx_eof(rx_eof), .frame_done(frame_done),
  .frame_accept(frame_accept));
